// ==== gpm_pin_mux.v ====
// Top of the pad controller: register port, address decode, readback and the bank of pad slices.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defs.vh"

module gpm_pin_mux #(
    parameter                          NUM_PADS   = `GPM_NUM_PADS,
    parameter [NUM_PADS*8-1:0]         MODE_VALID = {NUM_PADS{8'hff}}
) (
    input  wire                                clk_sys,
    input  wire                                reset_n,
    input  wire [`GPM_ADDR_W-1:0]              regAddr,
    input  wire [31:0]                         regWrData,
    input  wire                                regWrEn,
    input  wire                                regRdEn,
    output reg  [31:0]                         regRdData,
    input  wire [NUM_PADS-1:0]                 padIn,
    output wire [NUM_PADS-1:0]                 padOut,
    output wire [NUM_PADS-1:0]                 padOe,
    output wire [NUM_PADS-1:0]                 padPullUp,
    output wire [NUM_PADS-1:0]                 padPullDown,
    input  wire [NUM_PADS*`GPM_NUM_FUNC-1:0]   periphOut,
    input  wire [NUM_PADS*`GPM_NUM_FUNC-1:0]   periphOe,
    output wire [NUM_PADS*`GPM_NUM_FUNC-1:0]   periphIn,
    input  wire [NUM_PADS-1:0]                 debugMonitorBus
);

    // ======================================================================
    // Sizes of the readback views
    // Flag banks hold four words and the mode bank sixteen, so at most 128 pads fit.
    localparam FLAG_W = 128;
    localparam MODE_W = 512;
    localparam FPAD   = FLAG_W - NUM_PADS;
    localparam MPAD   = MODE_W - 4 * NUM_PADS;

    // ======================================================================
    // Bank decode
    wire                        selDir;
    wire                        selDout;
    wire                        selPullEn;
    wire                        selPullSel;
    wire                        selDin;
    wire                        selMode;
    wire [1:0]                  flagWord;
    wire [3:0]                  modeWord;

    assign selDir     = (regAddr[11:4] == `GPM_BANK_DIR);
    assign selDout    = (regAddr[11:4] == `GPM_BANK_DOUT);
    assign selPullEn  = (regAddr[11:4] == `GPM_BANK_PULLEN);
    assign selPullSel = (regAddr[11:4] == `GPM_BANK_PULLSEL);
    assign selDin     = (regAddr[11:4] == `GPM_BANK_DIN);
    assign selMode    = (regAddr[11:6] == `GPM_BANK_MODE);
    assign flagWord   = regAddr[3:2];
    assign modeWord   = regAddr[5:2];

    // ======================================================================
    // Per-pad state gathered for readback
    wire [NUM_PADS-1:0]                dirVec;
    wire [NUM_PADS-1:0]                doutVec;
    wire [NUM_PADS-1:0]                pullEnVec;
    wire [NUM_PADS-1:0]                pullSelVec;
    wire [NUM_PADS-1:0]                dinVec;
    wire [NUM_PADS*4-1:0]              modeVec;

    // ======================================================================
    // Pad slices
    genvar p;
    generate
        for (p = 0; p < NUM_PADS; p = p + 1) begin : gPad
            localparam [6:0] PIDX = p;
            wire                        inWord;
            wire                        inModeWord;
            wire [`GPM_MODE_W-1:0]      modeOut;

            assign inWord     = (flagWord == PIDX[6:5]);
            assign inModeWord = (modeWord == PIDX[6:3]);
            assign modeVec[4*p +: 4] = {1'b0, modeOut};

            gpm_pad_slice #(
                .MODE_VALID (MODE_VALID[8*p +: 8])
            ) uSlice (
                .clk_sys         (clk_sys),
                .reset_n         (reset_n),
                .wrDir           (regWrEn & selDir & inWord), // RQ2 RQ5
                .wrDout          (regWrEn & selDout & inWord), // RQ2 RQ5
                .wrPullEn        (regWrEn & selPullEn & inWord), // RQ5 RQ7
                .wrPullSel       (regWrEn & selPullSel & inWord), // RQ7
                .wrMode          (regWrEn & selMode & inModeWord), // RQ4
                .wrBit           (regWrData[PIDX[4:0]]),
                .wrModeVal       (regWrData[{PIDX[2:0], 2'b00} +: `GPM_MODE_W]), // RQ6
                .funcOut         (periphOut[`GPM_NUM_FUNC*p +: `GPM_NUM_FUNC]),
                .funcOe          (periphOe[`GPM_NUM_FUNC*p +: `GPM_NUM_FUNC]),
                .dbgBit          (debugMonitorBus[p]),
                .padIn           (padIn[p]),
                .dir_reg         (dirVec[p]),
                .dout_reg        (doutVec[p]),
                .pullEn_reg      (pullEnVec[p]),
                .pullSel_reg     (pullSelVec[p]),
                .mode_reg        (modeOut),
                .padInSample_reg (dinVec[p]),
                .padOut_reg      (padOut[p]),
                .padOe_reg       (padOe[p]),
                .pullUp_reg      (padPullUp[p]),
                .pullDown_reg    (padPullDown[p]),
                .funcIn_reg      (periphIn[`GPM_NUM_FUNC*p +: `GPM_NUM_FUNC])
            );
        end
    endgenerate

    // ======================================================================
    // Readback views padded with zeros above the last pad
    wire [FLAG_W-1:0]           dirView;
    wire [FLAG_W-1:0]           doutView;
    wire [FLAG_W-1:0]           pullEnView;
    wire [FLAG_W-1:0]           pullSelView;
    wire [FLAG_W-1:0]           dinView;
    wire [MODE_W-1:0]           modeView;

    assign dirView     = {{FPAD{1'b0}}, dirVec};
    assign doutView    = {{FPAD{1'b0}}, doutVec};
    assign pullEnView  = {{FPAD{1'b0}}, pullEnVec};
    assign pullSelView = {{FPAD{1'b0}}, pullSelVec};
    assign dinView     = {{FPAD{1'b0}}, dinVec};
    assign modeView    = {{MPAD{1'b0}}, modeVec};

    // ======================================================================
    // Read data, valid only in the cycle after the read strobe
    reg  [31:0]                 rdData_next;

    always @* begin
        rdData_next = `GPM_RST_WORD;
        if (regRdEn) begin
            if (selDir) begin
                rdData_next = dirView[{flagWord, 5'b00000} +: 32]; // RQ2
            end else if (selDout) begin
                rdData_next = doutView[{flagWord, 5'b00000} +: 32];
            end else if (selPullEn) begin
                rdData_next = pullEnView[{flagWord, 5'b00000} +: 32];
            end else if (selPullSel) begin
                rdData_next = pullSelView[{flagWord, 5'b00000} +: 32];
            end else if (selDin) begin
                rdData_next = dinView[{flagWord, 5'b00000} +: 32]; // RQ2
            end else if (selMode) begin
                rdData_next = modeView[{modeWord, 5'b00000} +: 32]; // RQ4
            end else begin
                rdData_next = `GPM_RST_WORD;
            end
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= `GPM_RST_WORD;
        end else begin
            regRdData <= rdData_next;
        end
    end

endmodule
`default_nettype wire

// ==== gpm_defs.vh ====
// Constants of the general-purpose pad controller and function multiplexer.
// How it works
// RQ1: The bank has 124 pads, each usable as a software-driven input/output line while mode 0 is selected.
// RQ2: Software sets each pad's direction and output level and reads back its sampled input level.
// RQ3: Each pad is shared between plain use and several peripheral signals, any one of which may reach it.
// RQ4: A per-pad mode field in a writable register chooses the function connected to the pad.
// RQ5: Direction, output level and pull enable sit in per-pad fields written in the same way as the mode fields.
// RQ6: The mode field takes values 0 to 7; mode 0 is the pad's own line and mode 7 a debug monitor bit.
// RQ7: Every pad has software pull-up and pull-down whatever the mode routes to it.
// RQ8: A mode with no function assigned leaves the pad undriven and feeds a low level to the peripheral input.
`ifndef GPM_DEFS_VH
`define GPM_DEFS_VH

// ==========================================================================
// Sizes
`define GPM_NUM_PADS        124
`define GPM_MODE_W          3
`define GPM_NUM_FUNC        6
`define GPM_ADDR_W          12

// ==========================================================================
// Mode codes
`define GPM_MODE_GPIO       3'h0
`define GPM_MODE_DEBUG      3'h7

// ==========================================================================
// Register banks: addr[11:4] selects a flag bank, addr[11:6] the mode bank
`define GPM_BANK_DIR        8'h00
`define GPM_BANK_DOUT       8'h01
`define GPM_BANK_PULLEN     8'h02
`define GPM_BANK_PULLSEL    8'h03
`define GPM_BANK_DIN        8'h04
`define GPM_BANK_MODE       6'h04

// ==========================================================================
// Reset values
`define GPM_RST_FLAG        1'b0
`define GPM_RST_MODE        3'h0
`define GPM_RST_WORD        32'h0000_0000

`endif

// ==== gpm_pad_slice.v ====
// One pad: its configuration fields, its output selection and its input routing.
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defs.vh"

module gpm_pad_slice #(
    parameter [7:0] MODE_VALID = 8'hff
) (
    input  wire                            clk_sys,
    input  wire                            reset_n,
    input  wire                            wrDir,
    input  wire                            wrDout,
    input  wire                            wrPullEn,
    input  wire                            wrPullSel,
    input  wire                            wrMode,
    input  wire                            wrBit,
    input  wire [`GPM_MODE_W-1:0]          wrModeVal,
    input  wire [`GPM_NUM_FUNC-1:0]        funcOut,
    input  wire [`GPM_NUM_FUNC-1:0]        funcOe,
    input  wire                            dbgBit,
    input  wire                            padIn,
    output reg                             dir_reg,
    output reg                             dout_reg,
    output reg                             pullEn_reg,
    output reg                             pullSel_reg,
    output reg  [`GPM_MODE_W-1:0]          mode_reg,
    output reg                             padInSample_reg,
    output reg                             padOut_reg,
    output reg                             padOe_reg,
    output reg                             pullUp_reg,
    output reg                             pullDown_reg,
    output reg  [`GPM_NUM_FUNC-1:0]        funcIn_reg
);

    // ======================================================================
    // Output selection
    reg                         padOut_next;
    reg                         padOe_next;
    reg  [`GPM_NUM_FUNC-1:0]    funcIn_next;
    wire                        modeLive;
    integer                     k;

    assign modeLive = MODE_VALID[mode_reg];

    always @* begin
        padOut_next = 1'b0;
        padOe_next  = 1'b0;
        funcIn_next = {`GPM_NUM_FUNC{1'b0}};
        if (!modeLive) begin
            padOut_next = 1'b0; // RQ8
            padOe_next  = 1'b0; // RQ8
        end else if (mode_reg == `GPM_MODE_GPIO) begin
            padOut_next = dout_reg; // RQ1 RQ2
            padOe_next  = dir_reg; // RQ1 RQ2
        end else if (mode_reg == `GPM_MODE_DEBUG) begin
            padOut_next = dbgBit; // RQ6
            padOe_next  = 1'b1; // RQ6
        end else begin
            for (k = 0; k < `GPM_NUM_FUNC; k = k + 1) begin
                if (mode_reg == k[`GPM_MODE_W-1:0] + 3'h1) begin
                    padOut_next    = funcOut[k]; // RQ3
                    padOe_next     = funcOe[k]; // RQ3
                    funcIn_next[k] = padIn; // RQ3
                end
            end
        end
    end

    // ======================================================================
    // Registers
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dir_reg         <= `GPM_RST_FLAG;
            dout_reg        <= `GPM_RST_FLAG;
            pullEn_reg      <= `GPM_RST_FLAG;
            pullSel_reg     <= `GPM_RST_FLAG;
            mode_reg        <= `GPM_RST_MODE;
            padInSample_reg <= 1'b0;
            padOut_reg      <= 1'b0;
            padOe_reg       <= 1'b0;
            pullUp_reg      <= 1'b0;
            pullDown_reg    <= 1'b0;
            funcIn_reg      <= {`GPM_NUM_FUNC{1'b0}};
        end else begin
            if (wrDir) begin
                dir_reg <= wrBit; // RQ5
            end
            if (wrDout) begin
                dout_reg <= wrBit; // RQ5
            end
            if (wrPullEn) begin
                pullEn_reg <= wrBit; // RQ5
            end
            if (wrPullSel) begin
                pullSel_reg <= wrBit;
            end
            if (wrMode) begin
                mode_reg <= wrModeVal; // RQ4
            end
            padInSample_reg <= padIn; // RQ2
            padOut_reg      <= padOut_next;
            padOe_reg       <= padOe_next;
            pullUp_reg      <= pullEn_reg & pullSel_reg; // RQ7
            pullDown_reg    <= pullEn_reg & ~pullSel_reg; // RQ7
            funcIn_reg      <= funcIn_next;
        end
    end

endmodule
`default_nettype wire

// ==== gpm_pin_mux_asserts.sv ====
// Checker of the pad controller: register read port and pad 0 paths.
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defs.vh"
module gpm_pin_mux_chk #(
    parameter                  NUM_PADS   = `GPM_NUM_PADS,
    parameter [NUM_PADS*8-1:0] MODE_VALID = {NUM_PADS{8'hff}}
) (
    input wire logic                           clk_sys,
    input wire logic                           reset_n,
    input wire logic [`GPM_ADDR_W-1:0]         regAddr,
    input wire logic [31:0]                    regWrData,
    input wire logic                           regWrEn,
    input wire logic                           regRdEn,
    input wire logic [31:0]                    regRdData,
    input wire logic [NUM_PADS-1:0]            padIn,
    input wire logic [NUM_PADS-1:0]            padOut,
    input wire logic [NUM_PADS-1:0]            padOe,
    input wire logic [NUM_PADS-1:0]            padPullUp,
    input wire logic [NUM_PADS-1:0]            padPullDown,
    input wire logic [NUM_PADS*`GPM_NUM_FUNC-1:0] periphOut,
    input wire logic [NUM_PADS*`GPM_NUM_FUNC-1:0] periphOe,
    input wire logic [NUM_PADS*`GPM_NUM_FUNC-1:0] periphIn,
    input wire logic [NUM_PADS-1:0]            debugMonitorBus
);
    // ==========================================================
    // Shadow of pad 0 fields: dir, dout, pull enable, pull select.
    logic [2:0] padMode_reg;
    logic [3:0] padCfg_reg;
    logic [2:0] fIdx;
    assign fIdx = padMode_reg - 3'h1;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            padMode_reg <= 3'h0;
            padCfg_reg  <= 4'h0;
        end else if (regWrEn) begin
            if (regAddr[11:2] == 10'h040)
                padMode_reg <= regWrData[2:0];
            if (regAddr[11:6] == 6'h00 && regAddr[3:2] == 2'h0)
                padCfg_reg[regAddr[5:4]] <= regWrData[0];
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_read_idle_zero: assert property (!$past(regRdEn) |-> regRdData == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    a_write_readback: assert property (regWrEn && regAddr == 12'h000 ##1 regRdEn && regAddr == 12'h000
        |=> regRdData == $past(regWrData, 2)) else $error("direction word not read back");
    a_gpio_follow: assert property ($past(padMode_reg) == 3'h0 |-> padOe[0] == $past(padCfg_reg[0])
        && padOut[0] == $past(padCfg_reg[1])) else $error("plain pad does not follow its fields");
    a_periph_drive: assert property ($past(padMode_reg) inside {[3'h1:3'h6]} && MODE_VALID[$past(padMode_reg)]
        |-> padOe[0] == $past(periphOe[fIdx]) && padOut[0] == $past(periphOut[fIdx]))
        else $error("peripheral not routed");
    a_periph_input: assert property ($past(padMode_reg) inside {[3'h1:3'h6]} && MODE_VALID[$past(padMode_reg)]
        |-> periphIn[$past(fIdx)] == $past(padIn[0])) else $error("pad level not fed to peripheral");
    a_debug_drive: assert property ($past(padMode_reg) == 3'h7 && MODE_VALID[7]
        |-> padOe[0] && padOut[0] == $past(debugMonitorBus[0])) else $error("debug bit not on pad");
    a_unassigned_idle: assert property (!MODE_VALID[$past(padMode_reg)]
        |-> !padOe[0] && !padOut[0] && periphIn[5:0] == 6'h00) else $error("unassigned mode is active");
    a_pull_follow: assert property (padPullUp[0] == $past(padCfg_reg[2] & padCfg_reg[3])
        && padPullDown[0] == $past(padCfg_reg[2] & ~padCfg_reg[3])) else $error("pull outputs wrong");
endmodule
bind gpm_pin_mux gpm_pin_mux_chk #(.NUM_PADS(NUM_PADS), .MODE_VALID(MODE_VALID)) i_gpm_pin_mux_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .padPullUp(padPullUp), .padPullDown(padPullDown), .periphOut(periphOut), .periphOe(periphOe),
    .periphIn(periphIn), .debugMonitorBus(debugMonitorBus));
`default_nettype wire

// ==== gpm_pin_mux_bench.sv ====
// Self-checking bench of the pad controller.
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defs.vh"
module gpm_pin_mux_bench;
    localparam int        NP = `GPM_NUM_PADS;
    localparam int        PW = NP * `GPM_NUM_FUNC;
    // Pad 0 has mode 5 unassigned.
    localparam [NP*8-1:0] MV = {{(NP-1){8'hff}}, 8'hdf};
    logic          clk_sys;
    logic          reset_n;
    logic [11:0]   regAddr;
    logic [31:0]   regWrData;
    logic          regWrEn;
    logic          regRdEn;
    logic [31:0]   regRdData;
    logic [NP-1:0] padIn, padOut, padOe, padPullUp, padPullDown, debugMonitorBus;
    logic [PW-1:0] periphOut, periphOe, periphIn;
    logic [5:0]    sel;
    int            nErrors;
    int            checksDone;
    logic [11:0]   rstAddr [6] = '{12'h000, 12'h010, 12'h020, 12'h030, 12'h13C, 12'h200};
    gpm_pin_mux #(.MODE_VALID(MV)) i_gpm_pin_mux (
        .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .padPullUp(padPullUp), .padPullDown(padPullDown), .periphOut(periphOut), .periphOe(periphOe),
        .periphIn(periphIn), .debugMonitorBus(debugMonitorBus));
    always #4 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            nErrors++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        regRdEn   <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regWrEn <= 1'b0;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        @(negedge clk_sys);
        chk(regRdData, exp);
    endtask
    task automatic idle();
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        nErrors++;
        end_of_test();
    end
    initial begin
        clk_sys = 1'b0;
        reset_n = 1'b0;
        regAddr = 12'h000;
        regWrData = 32'h0000_0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        padIn = '0;
        periphOut = '0;
        periphOe = '0;
        debugMonitorBus = '0;
        nErrors = 0;
        checksDone = 0;
        for (int r = 0; r < 2; r++) begin
            repeat (3) @(posedge clk_sys);
            reset_n <= 1'b1;
            foreach (rstAddr[i]) rd(rstAddr[i], 32'h0000_0000);
            $display("test reset values done");
            wr(12'h000, 32'hA5A5_A5A5);
            rd(12'h000, 32'hA5A5_A5A5);
            wr(12'h00C, 32'hFFFF_FFFF);
            rd(12'h00C, 32'h0FFF_FFFF);
            wr(12'h040, 32'hFFFF_FFFF);
            padIn[31:0] <= 32'h1234_5679;
            rd(12'h040, 32'h1234_5679);
            wr(12'h000, 32'h0000_0001);
            wr(12'h010, 32'h0000_0001);
            wr(12'h020, 32'h0000_0001);
            wr(12'h030, 32'h0000_0001);
            idle();
            chk({28'h0, padOe[0], padOut[0], padPullUp[0], padPullDown[0]}, 32'h0000_000E);
            wr(12'h030, 32'h0000_0000);
            idle();
            chk({30'h0, padPullUp[0], padPullDown[0]}, 32'h0000_0001);
            rd(12'h010, 32'h0000_0001);
            rd(12'h020, 32'h0000_0001);
            // A low output level keeps plain routing apart from peripheral and debug routing on the pad.
            wr(12'h010, 32'h0000_0000);
            $display("test registers and plain pad done");
            for (int m = 0; m < 8; m++) begin
                sel = (m >= 1 && m <= 6) ? 6'h01 << (m - 1) : 6'h00;
                wr(12'h100, 32'h0000_0008 | 32'(m));
                periphOut <= PW'(sel);
                periphOe <= PW'(sel);
                debugMonitorBus <= NP'(1'b1);
                rd(12'h100, 32'(m));
                chk({23'h0, padPullDown[0], padOe[0], padOut[0], periphIn[5:0]},
                    {23'h0, 1'b1, MV[m] ? {1'b1, (m != 0), sel} : 8'h00});
            end
            $display("test mode selection done");
            @(posedge clk_sys);
            reset_n <= 1'b0;
        end
        end_of_test();
    end
endmodule
`default_nettype wire
